// ---- verilog/adcs_pkg.sv ----
package adcs_pkg;
    // system clock and converter clock limits
    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    localparam int unsigned MIN_TAD_NS = 500;
    localparam int unsigned MIN_TAD_CYC =
        (MIN_TAD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    // register byte offsets
    localparam logic [4:0] OFF_CONTROL = 5'h00;
    localparam logic [4:0] OFF_CLK_SRC = 5'h04;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
    localparam logic [4:0] OFF_IRQ_CLR = 5'h0c;
    localparam logic [4:0] OFF_IRQ_EN = 5'h10;
    // adc_control field positions
    localparam int CTL_TRIG_BIT = 7;
    localparam int CTL_DONE_BIT = 6;
    localparam int CTL_PINS_LSB = 3;
    localparam int CTL_CHAN_LSB = 0;
    // adc_clock_source field positions
    localparam int CSR_OFF_BIT = 7;
    localparam int CSR_FAST_BIT = 6;
    localparam int CSR_DIV_LSB = 0;
    // reset values
    localparam logic [7:0] CTL_RST = 8'h40;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic IRQ_RST = 1'h0;
    // divider select codes and terminal counts
    localparam logic [1:0] DIV_SEL_2 = 2'h0;
    localparam logic [1:0] DIV_SEL_8 = 2'h1;
    localparam logic [1:0] DIV_SEL_32 = 2'h2;
    localparam logic [4:0] DIV_TERM_2 = 5'h01;
    localparam logic [4:0] DIV_TERM_8 = 5'h07;
    localparam logic [4:0] DIV_TERM_32 = 5'h1f;
    localparam int unsigned DIV_RATIO_2 = 2;
    // converter clock periods per conversion
    localparam logic [4:0] CONV_TICKS = 5'h10;
    // pin count code that selects every pin
    localparam logic [2:0] PINS_ALL = 3'h7;
    // interrupt status bit of the conversion end event
    localparam int IRQ_DONE_BIT = 0;
    // conversion sequencer states
    typedef enum {ST_IDLE, ST_HELD, ST_CONV} adcs_state_t;
endpackage : adcs_pkg

// ---- verilog/adcs_clk_div.sv ----
`timescale 1ns/100ps
module adcs_clk_div
    import adcs_pkg::*;
#(
    parameter int CNT_W = 5
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire logic i_run,
    input wire logic [1:0] i_sel,
    // converter clock enable
    output logic o_tick
);
    logic [CNT_W-1:0] cnt_q; // cycles since last tick
    logic [CNT_W-1:0] term; // last count of the period
    logic sel_ok; // divider code is defined

    // ratio decode; the undefined code never ticks
    assign sel_ok = (i_sel != 2'h3);
    assign term = (i_sel == DIV_SEL_2) ? CNT_W'(DIV_TERM_2) :
                  (i_sel == DIV_SEL_8) ? CNT_W'(DIV_TERM_8) :
                  CNT_W'(DIV_TERM_32);
    assign o_tick = i_run && sel_ok && (cnt_q == term);

    // count while running, cleared at each tick and when stopped
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else if (!i_run || o_tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : adcs_clk_div

// ---- verilog/adcs_control.sv ----
`timescale 1ns/100ps
module adcs_control
    import adcs_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // converter core
    output logic o_conv_power,
    output logic o_conv_reset,
    output logic o_conv_busy,
    output logic o_conv_clk_en,
    output logic [2:0] o_channel_select,
    output logic [7:0] o_channel_onehot,
    // port b pins
    output logic [7:0] o_analog_pin_en,
    output logic [7:0] o_pullhigh_off,
    // interrupt
    output logic o_irq
);
    // reset synchroniser
    logic rst_meta_q; // first stage
    logic rst_n; // released copy

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // register state
    logic trig_q; // conversion trigger bit
    logic done_n_q; // conversion_done_n flag
    logic [2:0] analog_pin_count_q; // pins used as analog
    logic [2:0] channel_select_q; // routed input
    logic converter_power_off_q; // power off bit
    logic clock_divider_sel_hi_q; // divider select high
    logic clock_divider_sel_lo_q; // divider select low
    logic irq_stat_q; // sticky end event
    logic irq_en_q; // end event enable
    adcs_state_t state_q; // sequencer state
    logic [4:0] tick_cnt_q; // converter periods so far
    logic ack_q; // bus answer cycle
    logic [31:0] rdata_q; // read data

    // bus decode
    wire req = i_avs_read || i_avs_write;
    wire wr_go = i_avs_write && !ack_q;
    wire lane0 = i_avs_byteenable[0];
    wire wr_ctl = wr_go && lane0 && (i_avs_address == OFF_CONTROL);
    wire wr_csr = wr_go && lane0 && (i_avs_address == OFF_CLK_SRC);
    wire wr_clr = wr_go && lane0 && (i_avs_address == OFF_IRQ_CLR);
    wire wr_en = wr_go && lane0 && (i_avs_address == OFF_IRQ_EN);
    wire wd_trig = i_avs_writedata[CTL_TRIG_BIT];
    wire [1:0] div_sel = {clock_divider_sel_hi_q, clock_divider_sel_lo_q};

    // trigger edges seen through the control write
    wire trig_rise = wr_ctl && !trig_q && wd_trig;
    wire trig_fall = wr_ctl && trig_q && !wd_trig;

    // power gate
    wire powered = (analog_pin_count_q != 3'h0) && !converter_power_off_q;

    // converter clock divider runs only during a conversion
    wire tick;
    wire conv_run = (state_q == ST_CONV) && powered;
    wire conv_end = tick && (tick_cnt_q == CONV_TICKS - 5'h01);

    adcs_clk_div #(
        .CNT_W(5)
    ) u_clk_div (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n),
        .i_run(conv_run),
        .i_sel(div_sel),
        .o_tick(tick)
    );

    // divide by 2 ratio below minimum period, shown to software
    wire too_fast = (div_sel == DIV_SEL_2) && (DIV_RATIO_2 < MIN_TAD_CYC);

    // analog pin mask
    wire [7:0] pin_mask = (analog_pin_count_q == PINS_ALL) ? 8'hff :
        8'((9'h001 << analog_pin_count_q) - 9'h001);

    // read words, control layout
    wire [7:0] ctl_word = {trig_q, done_n_q, analog_pin_count_q,
                           channel_select_q};
    wire [7:0] csr_word = {converter_power_off_q, too_fast, 4'h0,
                           clock_divider_sel_hi_q, clock_divider_sel_lo_q};
    wire [31:0] rd_mux =
        (i_avs_address == OFF_CONTROL) ? {24'h0, ctl_word} :
        (i_avs_address == OFF_CLK_SRC) ? {24'h0, csr_word} :
        (i_avs_address == OFF_IRQ_STAT) ? {31'h0, irq_stat_q} :
        (i_avs_address == OFF_IRQ_EN) ? {31'h0, irq_en_q} :
        32'h0;

    // bus answer: one wait cycle, then waitrequest low
    assign o_avs_waitrequest = req && !ack_q;
    assign o_avs_readdata = rdata_q;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req && !ack_q;
            rdata_q <= (i_avs_read && !ack_q) ? rd_mux : 32'h0;
        end
    end

    // software fields of adc_control and adc_clock_source
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_q <= CTL_RST[CTL_TRIG_BIT];
            analog_pin_count_q <= CTL_RST[CTL_PINS_LSB +: 3];
            channel_select_q <= CTL_RST[CTL_CHAN_LSB +: 3];
            converter_power_off_q <= CSR_RST[CSR_OFF_BIT];
            clock_divider_sel_hi_q <= CSR_RST[CSR_DIV_LSB + 1];
            clock_divider_sel_lo_q <= CSR_RST[CSR_DIV_LSB];
        end else begin
            if (wr_ctl) begin
                // done bit position is not stored
                trig_q <= wd_trig;
                analog_pin_count_q <= i_avs_writedata[CTL_PINS_LSB +: 3];
                channel_select_q <= i_avs_writedata[CTL_CHAN_LSB +: 3];
            end
            if (wr_csr) begin
                converter_power_off_q <= i_avs_writedata[CSR_OFF_BIT];
                clock_divider_sel_hi_q <= i_avs_writedata[CSR_DIV_LSB + 1];
                clock_divider_sel_lo_q <= i_avs_writedata[CSR_DIV_LSB];
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            tick_cnt_q <= 5'h0;
            done_n_q <= CTL_RST[CTL_DONE_BIT];
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (trig_rise) begin
                        state_q <= ST_HELD;
                        done_n_q <= 1'b1;
                    end
                end
                ST_HELD: begin
                    // held in reset until trigger falls
                    if (trig_fall) begin
                        state_q <= ST_CONV;
                        tick_cnt_q <= 5'h0;
                    end
                end
                ST_CONV: begin
                    if (trig_rise) begin
                        state_q <= ST_HELD; // restart aborts
                        done_n_q <= 1'b1;
                    end else if (conv_end) begin
                        state_q <= ST_IDLE;
                        done_n_q <= 1'b0;
                    end else if (tick) begin
                        tick_cnt_q <= tick_cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // interrupt status, clear and enable; set wins over clear
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= IRQ_RST;
            irq_en_q <= IRQ_RST;
        end else begin
            if (conv_end) begin
                irq_stat_q <= 1'b1;
            end else if (wr_clr && i_avs_writedata[IRQ_DONE_BIT]) begin
                irq_stat_q <= 1'b0;
            end
            if (wr_en) begin
                irq_en_q <= i_avs_writedata[IRQ_DONE_BIT];
            end
        end
    end

    // converter and pin outputs
    assign o_irq = irq_stat_q && irq_en_q;
    assign o_conv_power = powered;
    assign o_conv_reset = (state_q == ST_HELD);
    assign o_conv_busy = (state_q == ST_CONV);
    assign o_conv_clk_en = tick;
    assign o_channel_select = channel_select_q;
    assign o_channel_onehot = 8'(9'h001 << channel_select_q);
    assign o_analog_pin_en = pin_mask;
    assign o_pullhigh_off = pin_mask;

    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_pins_zero: assert property (
        analog_pin_count_q == 3'h0 |-> o_analog_pin_en == 8'h00)
        else $error("pins enabled with zero count");
    a_pins_all: assert property (
        analog_pin_count_q == PINS_ALL |-> o_analog_pin_en == 8'hff)
        else $error("count seven must enable all pins");
    a_power_gate: assert property (
        o_conv_power == ((analog_pin_count_q != 3'h0)
                         && !converter_power_off_q))
        else $error("converter power wrong");
    a_held_done: assert property (
        state_q == ST_HELD |-> done_n_q && o_conv_reset)
        else $error("held converter must show done high");
    a_start_conv: assert property (
        state_q == ST_HELD && trig_fall |=> o_conv_busy && done_n_q)
        else $error("trigger fall did not start conversion");
    a_busy_done: assert property (
        o_conv_busy |-> done_n_q)
        else $error("done low during conversion");
    a_end_clear: assert property (
        o_conv_busy && conv_end && !trig_rise |=> !done_n_q && !o_conv_busy)
        else $error("done not cleared at end");
    a_end_irq: assert property (
        conv_end |=> irq_stat_q)
        else $error("end event not latched");
    a_irq_level: assert property (
        irq_stat_q && irq_en_q && !wr_en
        |-> o_irq ##1 (o_irq || !irq_stat_q))
        else $error("enabled request not on output");
    a_tick_bound: assert property (
        o_conv_busy |-> tick_cnt_q < CONV_TICKS)
        else $error("conversion overran sixteen periods");
    a_div_two: assert property (
        tick && conv_run && div_sel == DIV_SEL_2 && !conv_end
        |=> !tick ##1 (tick || !conv_run))
        else $error("divide by two spacing wrong");
    a_chan_route: assert property (
        $onehot(o_channel_onehot)
        && o_channel_onehot[channel_select_q])
        else $error("channel route not one hot");
    a_done_ro: assert property (
        state_q == ST_IDLE && !trig_rise |=> done_n_q == $past(done_n_q))
        else $error("done flag changed by write");

    // sequencer, divider, flag and pin mask checks
    a_rise_reset: assert property (
        trig_rise |=> o_conv_reset && done_n_q && !o_conv_busy)
        else $error("trigger rise did not hold converter");
    a_done_hold: assert property (
        !done_n_q && !trig_rise |=> !done_n_q)
        else $error("done flag left low state early");
    a_tick_powered: assert property (
        o_conv_clk_en |-> o_conv_busy && o_conv_power)
        else $error("converter clock while off or idle");
    a_div_eight: assert property (
        tick && conv_run && div_sel == DIV_SEL_8
        |=> !tick [*7])
        else $error("divide by eight spacing wrong");
    a_stat_sticky: assert property (
        irq_stat_q && !(wr_clr && i_avs_writedata[IRQ_DONE_BIT])
        |=> irq_stat_q)
        else $error("status bit lost without clear");
    a_pins_low: assert property (
        analog_pin_count_q != PINS_ALL
        |-> $countones(o_analog_pin_en) == int'(analog_pin_count_q)
        && ((o_analog_pin_en + 8'h01) & o_analog_pin_en) == 8'h00)
        else $error("pin mask not the lowest pins");
endmodule : adcs_control

// ---- test/adcs_conv_model.sv ----
`timescale 1ns/100ps
// converter core stand-in: counts what the block hands it
module adcs_conv_model (
    // clock
    input wire logic i_clk_sys,
    // converter controls
    input wire logic i_conv_reset,
    input wire logic i_conv_busy,
    input wire logic i_conv_clk_en,
    // counts for the bench
    output logic [31:0] o_busy_cycles,
    output logic [31:0] o_ticks
);
    // counts restart while the core is held in reset
    always_ff @(posedge i_clk_sys) begin
        if (i_conv_reset) begin
            o_busy_cycles <= 32'h0;
            o_ticks <= 32'h0;
        end else begin
            // cycles spent converting
            if (i_conv_busy) begin
                o_busy_cycles <= o_busy_cycles + 32'h1;
            end
            // every enable counts, powered or not
            if (i_conv_clk_en) begin
                o_ticks <= o_ticks + 32'h1;
            end
        end
    end
endmodule : adcs_conv_model

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import adcs_pkg::*;
    // stimulus
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    // observed
    logic [31:0] rdata, busy_cyc, ticks;
    logic wait_req, pwr, crst, busy, clk_en, irq;
    logic [2:0] chan;
    logic [7:0] onehot, ana_en, pull_off;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] lfsr = 32'h4c07a633;

    // 40 mhz clock
    always #12.5 clk = ~clk;

    adcs_control i_dut (.i_clk_sys(clk), .i_resetn(resetn),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .o_conv_power(pwr), .o_conv_reset(crst), .o_conv_busy(busy),
        .o_conv_clk_en(clk_en), .o_channel_select(chan),
        .o_channel_onehot(onehot), .o_analog_pin_en(ana_en),
        .o_pullhigh_off(pull_off), .o_irq(irq));

    adcs_conv_model i_conv (.i_clk_sys(clk), .i_conv_reset(crst),
        .i_conv_busy(busy), .i_conv_clk_en(clk_en),
        .o_busy_cycles(busy_cyc), .o_ticks(ticks));

    // random step
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // analog pin mask for a pin count code
    function automatic logic [7:0] pin_mask(input logic [2:0] n);
        pin_mask = (n == PINS_ALL) ? 8'hff : 8'((9'h001 << n) - 9'h001);
    endfunction : pin_mask
    // clock source readback, too-fast flag follows divide by 2
    function automatic logic [31:0] csr_rd(input logic [7:0] v);
        csr_rd = {24'h0, v[7], v[1:0] == DIV_SEL_2, 4'h0, v[1:0]};
    endfunction : csr_rd

    // verdict and end of run
    task automatic final_report;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // compare one value
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        if (k >= 50) bad_count++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // register write
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask : wr_reg
    // register read and compare
    task automatic rd_chk(input string name, input logic [4:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask : rd_chk
    // wait for the conversion to finish, bounded
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (busy !== 1'b0 && k < 2000);
        if (k >= 2000) bad_count++;
    endtask : wait_idle

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end

    // main sequence
    initial begin
        logic [7:0] ctl;
        logic [31:0] t0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values and an unmapped place
        rd_chk("control", OFF_CONTROL, {24'h0, CTL_RST});
        rd_chk("clk_src", OFF_CLK_SRC, csr_rd(CSR_RST));
        rd_chk("irq_stat", OFF_IRQ_STAT, 32'h0);
        rd_chk("unmapped", 5'h14, 32'h0);
        // narrow byte lanes and the status place ignore writes
        be <= 4'he;
        wr_reg(OFF_CONTROL, 8'h3f);
        be <= 4'hf;
        wr_reg(OFF_IRQ_STAT, 8'h01);
        rd_chk("control", OFF_CONTROL, {24'h0, CTL_RST});
        rd_chk("irq_stat", OFF_IRQ_STAT, 32'h0);
        rd_chk("irq_clr", OFF_IRQ_CLR, 32'h0);
        chk("power", 32'h0, pwr);
        // every pin count code with a random channel
        for (int n = 0; n < 8; n++) begin
            lfsr = lfsr_next(lfsr);
            ctl = {2'b00, 3'(n), lfsr[2:0]};
            wr_reg(OFF_CONTROL, ctl);
            chk("pin_en", pin_mask(3'(n)), ana_en);
            chk("pull_off", pin_mask(3'(n)), pull_off);
            chk("power", n != 0, pwr);
            chk("onehot", 8'h01 << lfsr[2:0], onehot);
            chk("chan", lfsr[2:0], chan);
        end
        rd_chk("control", OFF_CONTROL, ctl | 8'h40);
        // power-off bit alone turns the core off
        wr_reg(OFF_CLK_SRC, 8'h80);
        chk("power", 32'h0, pwr);
        // a conversion per divider code, divide by 2 flagged too fast
        for (int s = 0; s < 3; s++) begin
            lfsr = lfsr_next(lfsr);
            ctl = {2'b00, lfsr[5:3] | 3'h1, lfsr[2:0]};
            wr_reg(OFF_CLK_SRC, 8'(s));
            rd_chk("clk_src", OFF_CLK_SRC, csr_rd(8'(s)));
            wr_reg(OFF_IRQ_EN, 8'(s != 0));
            wr_reg(OFF_CONTROL, ctl);
            wr_reg(OFF_CONTROL, ctl | 8'h80);
            chk("conv_reset", 32'h1, crst);
            chk("busy", 32'h0, busy);
            rd_chk("control", OFF_CONTROL, ctl | 8'hc0);
            wr_reg(OFF_CONTROL, ctl | 8'h40);
            rd_chk("control", OFF_CONTROL, ctl | 8'h40);
            wait_idle();
            chk("busy_cyc", 16 * (2 << (2 * s)), busy_cyc);
            chk("ticks", 32'd16, ticks);
            rd_chk("control", OFF_CONTROL, ctl);
            // a one written to the done place must not raise it
            wr_reg(OFF_CONTROL, ctl | 8'h40);
            rd_chk("control", OFF_CONTROL, ctl);
            rd_chk("irq_stat", OFF_IRQ_STAT, 32'h1);
            chk("irq", s != 0, irq);
            wr_reg(OFF_IRQ_EN, 8'h01);
            chk("irq", 32'h1, irq);
            rd_chk("irq_en", OFF_IRQ_EN, 32'h1);
            wr_reg(OFF_IRQ_CLR, 8'h01);
            chk("irq", 32'h0, irq);
            rd_chk("irq_stat", OFF_IRQ_STAT, 32'h0);
        end
        // undefined divider code never ticks, a new rise aborts
        wr_reg(OFF_CLK_SRC, 8'h03);
        wr_reg(OFF_CONTROL, ctl | 8'h80);
        wr_reg(OFF_CONTROL, ctl);
        repeat (100) @(posedge clk);
        chk("busy", 32'h1, busy);
        chk("ticks", 32'h0, ticks);
        wr_reg(OFF_CONTROL, ctl | 8'h80);
        chk("busy", 32'h0, busy);
        // power off in mid conversion stalls the count
        wr_reg(OFF_CLK_SRC, 8'h01);
        wr_reg(OFF_CONTROL, ctl);
        wr_reg(OFF_CLK_SRC, 8'h81);
        t0 = ticks;
        repeat (100) @(posedge clk);
        chk("ticks", t0, ticks);
        wr_reg(OFF_CLK_SRC, 8'h01);
        wait_idle();
        chk("ticks", 32'd16, ticks);
        final_report();
    end
endmodule : tb_top
